// *** pkg/dlcr_consts.svh ***
// Offsets, field positions, reset values and depths of the dither and link registers
`ifndef DLCR_CONSTS_SVH
`define DLCR_CONSTS_SVH

`define DLCR_ADDR_W 12
`define DLCR_OFF_DITHER 12'h09D
`define DLCR_OFF_LSB 12'h160
`define DLCR_OFF_LINK_EN 12'h200
`define DLCR_OFF_MODE 12'h201
`define DLCR_OFF_MF_LEN 12'h202
`define DLCR_OFF_AUX 12'h20E
`define DLCR_OFF_LOCK 12'h20F

`define DLCR_RST_DITHER 8'h01
`define DLCR_RST_LSB 8'h00
`define DLCR_RST_LINK_EN 8'h01
`define DLCR_RST_MODE 8'h02
`define DLCR_RST_MF_LEN 8'h1F
`define DLCR_RST_AUX 8'h01
`define DLCR_RST_LOCK 8'hFF
`define DLCR_RDATA_NONE 8'h00

`define DLCR_BIT_DITHER_ON 0
`define DLCR_BIT_DITHER_AMP 1
`define DLCR_BIT_ROUND_ERR 2
`define DLCR_BIT_MARKER_EN 0
`define DLCR_BIT_LINK_EN 0
`define DLCR_BIT_CAL_EN 0
`define DLCR_BIT_SYNC_RX 1

`define DLCR_MODE_66_FIRST 8'h10
`define DLCR_K66_MINUS_ONE 8'hFF
`define DLCR_MARK_DEPTH 4
`define DLCR_SAMPLE_W 12
`define DLCR_LSB_12 0
`define DLCR_LSB_8 4
`define DLCR_ILA_CS_W 2

`endif

// *** pkg/dlcr_pkg.sv ***
// Types shared by the dither and link register bank
`default_nettype none

package dlcr_pkg;
    typedef logic [7:0] dlcr_byte_t;
    typedef enum logic [0:0] {
        DLCR_FMT_12BIT = 1'b0,
        DLCR_FMT_8BIT = 1'b1
    } dlcr_fmt_t;
endpackage

`default_nettype wire

// *** hw/dlcr_marker_align.sv ***
// Marker delay line matching the sample pipeline latency
`timescale 1ns/10ps
`default_nettype none
`include "dlcr_consts.svh"

module dlcr_marker_align (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic sample_valid,
    input wire logic marker_in,
    output logic marker_out
);
    logic [`DLCR_MARK_DEPTH-1:0] stage_q;

    // One stage per sample, so marker and sample advance together
    genvar i;
    generate
        for (i = 0; i < `DLCR_MARK_DEPTH; i++)
        begin : g_stage
            always_ff @(posedge ref_clk or negedge arst_n)
            begin
                if (!arst_n)
                    stage_q[i] <= 1'b0;
                else if (sample_valid)
                    stage_q[i] <= (i == 0) ? marker_in : stage_q[(i == 0) ? 0 : i-1];
            end
        end
    endgenerate

    assign marker_out = stage_q[`DLCR_MARK_DEPTH-1];

    a_stage_entry: assert property (@(posedge ref_clk) disable iff (!arst_n)
        sample_valid |=> stage_q[0] == $past(marker_in))
        else $error("marker not captured on sample");
    a_stage_hold: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !sample_valid |=> $stable(stage_q))
        else $error("marker moved without a sample");
endmodule // dlcr_marker_align

`default_nettype wire

// *** hw/dlcr_regs.sv ***
// Dither, sample marker and output link configuration registers
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "dlcr_consts.svh"

// How it works
// - Dither control bit 0 turns dither on; resets to one.
// - Dither control bit 1 picks small (0) or large (1) amplitude.
// - Dither control bit 2 steers rounding error to noise or offset and spurs.
// - Sample control bit 0 puts the marker on each sample LSB; resets off.
// - Marker is delayed exactly like the samples, staying aligned.
// - Marker takes LSB of 8-bit samples or of 12-bit word.
// - Control bits per sample advertised in lane alignment data stays zero.
// - Link enable bit 0 enables the output link; resets to one.
// - Link disabled holds link in reset, serializers down, clocks gated.
// - Link disabled holds multiframe counter reset; SYSREF ignored.
// - Eight-bit link mode register selects output mode; resets to two.
// - Only link modes allowed by the mode lock setting are accepted.
// - Multiframe length register holds frames per multiframe minus one; resets 0x1F.
// - In 64b/66b modes frame count comes from mode, not the register.
module dlcr_regs (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [`DLCR_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic sync_pin,
    input wire logic sysref_pin,
    input wire logic frame_tick,
    input wire logic sample_valid,
    input wire logic [`DLCR_SAMPLE_W-1:0] sample_in,
    input wire dlcr_pkg::dlcr_fmt_t sample_fmt,
    output logic dither_on,
    output logic dither_amplitude_select,
    output logic rounding_error_select,
    output logic marker_bit_enable,
    output logic sync_receiver_on,
    output logic cal_enable,
    output logic link_subsystem_enable,
    output logic link_hold_reset,
    output logic serializer_power_down,
    output logic link_clock_enable,
    output logic [7:0] link_mode_select,
    output logic [7:0] frames_per_multiframe_minus_one,
    output logic lmfc_boundary,
    output logic [`DLCR_ILA_CS_W-1:0] ila_control_bits,
    output logic sample_out_valid,
    output logic [`DLCR_SAMPLE_W-1:0] sample_out
);
    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    dlcr_pkg::dlcr_byte_t dither_q;
    dlcr_pkg::dlcr_byte_t lsb_q;
    dlcr_pkg::dlcr_byte_t link_en_q;
    dlcr_pkg::dlcr_byte_t mode_q;
    dlcr_pkg::dlcr_byte_t mf_len_q;
    dlcr_pkg::dlcr_byte_t aux_q;
    dlcr_pkg::dlcr_byte_t lock_q;
    logic mode_ok;

    // Modes above the lock value are refused
    assign mode_ok = (reg_wdata <= lock_q);

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dither_q <= `DLCR_RST_DITHER;
            lsb_q <= `DLCR_RST_LSB;
            link_en_q <= `DLCR_RST_LINK_EN;
            mode_q <= `DLCR_RST_MODE;
            mf_len_q <= `DLCR_RST_MF_LEN;
            aux_q <= `DLCR_RST_AUX;
            lock_q <= `DLCR_RST_LOCK;
        end
        else if (reg_wr)
        begin
            unique case (reg_addr)
                `DLCR_OFF_DITHER: dither_q <= reg_wdata;
                `DLCR_OFF_LSB: lsb_q <= reg_wdata;
                `DLCR_OFF_LINK_EN: link_en_q <= reg_wdata;
                `DLCR_OFF_MODE: if (mode_ok) mode_q <= reg_wdata;
                `DLCR_OFF_MF_LEN: mf_len_q <= reg_wdata;
                `DLCR_OFF_AUX: aux_q <= reg_wdata;
                `DLCR_OFF_LOCK: lock_q <= reg_wdata;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read port, data in the cycle after the strobe only
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            reg_rdata <= `DLCR_RDATA_NONE;
        else if (reg_rd)
        begin
            unique case (reg_addr)
                `DLCR_OFF_DITHER: reg_rdata <= dither_q;
                `DLCR_OFF_LSB: reg_rdata <= lsb_q;
                `DLCR_OFF_LINK_EN: reg_rdata <= link_en_q;
                `DLCR_OFF_MODE: reg_rdata <= mode_q;
                `DLCR_OFF_MF_LEN: reg_rdata <= mf_len_q;
                `DLCR_OFF_AUX: reg_rdata <= aux_q;
                `DLCR_OFF_LOCK: reg_rdata <= lock_q;
                default: reg_rdata <= `DLCR_RDATA_NONE;
            endcase
        end
        else
            reg_rdata <= `DLCR_RDATA_NONE;
    end

    // ------------------------------------------------------------
    // Control outputs
    // ------------------------------------------------------------
    logic link_on;
    logic mode_is_66;
    assign link_on = link_en_q[`DLCR_BIT_LINK_EN];
    assign mode_is_66 = (mode_q >= `DLCR_MODE_66_FIRST);

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dither_on <= 1'b0;
            dither_amplitude_select <= 1'b0;
            rounding_error_select <= 1'b0;
            marker_bit_enable <= 1'b0;
            sync_receiver_on <= 1'b0;
            cal_enable <= 1'b0;
            link_subsystem_enable <= 1'b0;
            link_hold_reset <= 1'b1;
            serializer_power_down <= 1'b1;
            link_clock_enable <= 1'b0;
            link_mode_select <= 8'h00;
            frames_per_multiframe_minus_one <= 8'h00;
            ila_control_bits <= '0;
        end
        else
        begin
            dither_on <= dither_q[`DLCR_BIT_DITHER_ON];
            dither_amplitude_select <= dither_q[`DLCR_BIT_DITHER_AMP];
            rounding_error_select <= dither_q[`DLCR_BIT_ROUND_ERR];
            marker_bit_enable <= lsb_q[`DLCR_BIT_MARKER_EN];
            sync_receiver_on <= aux_q[`DLCR_BIT_SYNC_RX];
            cal_enable <= aux_q[`DLCR_BIT_CAL_EN];
            link_subsystem_enable <= link_on;
            link_hold_reset <= !link_on;
            serializer_power_down <= !link_on;
            link_clock_enable <= link_on;
            link_mode_select <= mode_q;
            frames_per_multiframe_minus_one <= mode_is_66 ? `DLCR_K66_MINUS_ONE : mf_len_q;
            ila_control_bits <= '0;
        end
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic sync_s1_q;
    logic sync_s2_q;
    logic sysref_s1_q;
    logic sysref_s2_q;
    logic sysref_s3_q;

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sync_s1_q <= 1'b0;
            sync_s2_q <= 1'b0;
            sysref_s1_q <= 1'b0;
            sysref_s2_q <= 1'b0;
            sysref_s3_q <= 1'b0;
        end
        else
        begin
            sync_s1_q <= sync_pin;
            sync_s2_q <= sync_s1_q;
            sysref_s1_q <= sysref_pin;
            sysref_s2_q <= sysref_s1_q;
            sysref_s3_q <= sysref_s2_q;
        end
    end

    // ------------------------------------------------------------
    // Local multiframe counter
    // ------------------------------------------------------------
    logic sysref_rise;
    logic [7:0] lmfc_cnt_q;
    logic lmfc_wrap;
    // Edges only count while the link runs
    assign sysref_rise = sysref_s2_q && !sysref_s3_q && link_subsystem_enable;
    assign lmfc_wrap = frame_tick && (lmfc_cnt_q == frames_per_multiframe_minus_one);

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            lmfc_cnt_q <= 8'h00;
        else if (!link_subsystem_enable)
            lmfc_cnt_q <= 8'h00;
        else if (sysref_rise)
            lmfc_cnt_q <= 8'h00;
        else if (lmfc_wrap)
            lmfc_cnt_q <= 8'h00;
        else if (frame_tick)
            lmfc_cnt_q <= lmfc_cnt_q + 8'h01;
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            lmfc_boundary <= 1'b0;
        else
            lmfc_boundary <= link_subsystem_enable && !sysref_rise && lmfc_wrap;
    end

    // ------------------------------------------------------------
    // Marker insertion on the sample LSB
    // ------------------------------------------------------------
    logic marker_src;
    logic marker_dly;
    logic [`DLCR_SAMPLE_W-1:0] sample_mark;
    // Marker is taken from the sync receiver
    assign marker_src = sync_s2_q && sync_receiver_on;

    dlcr_marker_align u_align (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .sample_valid(sample_valid),
        .marker_in(marker_src),
        .marker_out(marker_dly)
    );

    always_comb
    begin
        sample_mark = sample_in;
        if (sample_fmt == dlcr_pkg::DLCR_FMT_8BIT)
        begin
            sample_mark[`DLCR_LSB_8-1:0] = '0;
            if (marker_bit_enable)
                sample_mark[`DLCR_LSB_8] = marker_dly;
        end
        else if (marker_bit_enable)
            sample_mark[`DLCR_LSB_12] = marker_dly;
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sample_out_valid <= 1'b0;
            sample_out <= '0;
        end
        else
        begin
            sample_out_valid <= sample_valid;
            if (sample_valid)
                sample_out <= sample_mark;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    a_dither_follow: assert property (reg_wr && reg_addr == `DLCR_OFF_DITHER |-> ##2
        dither_on == $past(reg_wdata[`DLCR_BIT_DITHER_ON], 2)
        && rounding_error_select == $past(reg_wdata[`DLCR_BIT_ROUND_ERR], 2))
        else $error("dither control not applied");
    a_amp_follow: assert property (reg_wr && reg_addr == `DLCR_OFF_DITHER ##1 !reg_wr |=>
        dither_amplitude_select == $past(reg_wdata[`DLCR_BIT_DITHER_AMP], 2))
        else $error("dither amplitude not applied");
    a_reserved_back: assert property (reg_wr && reg_addr == `DLCR_OFF_LSB ##1 reg_rd
        && reg_addr == `DLCR_OFF_LSB && !reg_wr |=> reg_rdata == $past(reg_wdata, 2))
        else $error("reserved bits not stored");
    a_link_off_state: assert property (!link_subsystem_enable |->
        link_hold_reset && serializer_power_down && !link_clock_enable)
        else $error("disabled link not held down");
    a_link_follow: assert property (reg_wr && reg_addr == `DLCR_OFF_LINK_EN |-> ##2
        link_subsystem_enable == $past(reg_wdata[`DLCR_BIT_LINK_EN], 2))
        else $error("link enable not applied");
    a_lmfc_held: assert property (!link_subsystem_enable |=> lmfc_cnt_q == 8'h00
        && !lmfc_boundary)
        else $error("frame counter runs while link off");
    a_mode_lock: assert property (reg_wr && reg_addr == `DLCR_OFF_MODE && reg_wdata > lock_q
        |=> $stable(mode_q))
        else $error("locked mode accepted");
    a_mode_take: assert property (reg_wr && reg_addr == `DLCR_OFF_MODE && mode_ok |-> ##2
        link_mode_select == $past(reg_wdata, 2))
        else $error("link mode not applied");
    a_mf_len_66: assert property (arst_n && mode_is_66 |=> frames_per_multiframe_minus_one
        == `DLCR_K66_MINUS_ONE)
        else $error("frame count not taken from mode");
    a_mf_len_reg: assert property (arst_n && !mode_is_66 |=> frames_per_multiframe_minus_one
        == $past(mf_len_q))
        else $error("frame count register ignored");
    a_ila_zero: assert property (ila_control_bits == '0)
        else $error("marker advertised in alignment data");
    a_marker_off: assert property (sample_valid && !marker_bit_enable
        && sample_fmt == dlcr_pkg::DLCR_FMT_12BIT |=> sample_out == $past(sample_in))
        else $error("sample altered while marking off");
    a_marker_8bit: assert property (sample_valid && marker_bit_enable
        && sample_fmt == dlcr_pkg::DLCR_FMT_8BIT |=> sample_out[`DLCR_LSB_8] == $past(marker_dly)
        && sample_out[`DLCR_LSB_8-1:0] == '0)
        else $error("8-bit marker misplaced");
    a_read_once: assert property (!reg_rd |=> reg_rdata == `DLCR_RDATA_NONE)
        else $error("read data outside read cycle");

    c_link_cycle: cover property (link_subsystem_enable ##1 !link_subsystem_enable
        ##[1:20] link_subsystem_enable);
    c_sysref_align: cover property (sysref_rise && lmfc_cnt_q != 8'h00);
    c_marker_out: cover property (sample_out_valid && marker_bit_enable && sample_out[0]);
    c_mode_refused: cover property (reg_wr && reg_addr == `DLCR_OFF_MODE && !mode_ok);
endmodule // dlcr_regs

`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench for the dither, sample marker and link configuration registers
`timescale 1ns/10ps
`default_nettype none
`include "dlcr_consts.svh"

`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin bad_count++; \
    $display("unexpected %s expected %0h seen %0h", nm, ex, got); end end

module testbench;
    // ----------------------------------------
    // Stimulus, observation and model state
    // ----------------------------------------
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic sync_pin = 1'b0;
    logic sysref_pin = 1'b0;
    logic frame_tick = 1'b0;
    logic sample_valid = 1'b0;
    logic [11:0] sample_in = 12'h000;
    dlcr_pkg::dlcr_fmt_t sample_fmt = dlcr_pkg::DLCR_FMT_12BIT;
    logic dither_on, dither_amplitude_select, rounding_error_select, marker_bit_enable;
    logic sync_receiver_on, cal_enable, link_subsystem_enable, link_hold_reset;
    logic serializer_power_down, link_clock_enable, lmfc_boundary, sample_out_valid;
    logic [7:0] link_mode_select, frames_per_multiframe_minus_one;
    logic [1:0] ila_control_bits;
    logic [11:0] sample_out;
    int bad_count = 0;
    int comparisons = 0;
    int seed = 98740;
    int m [int];
    int addrs [5] = '{'h09D, 'h160, 'h201, 'h202, 'h20F};
    int k, a, d, pulses;

    always #4 ref_clk = ~ref_clk;

    dlcr_regs dut_u (
        .ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sync_pin(sync_pin),
        .sysref_pin(sysref_pin), .frame_tick(frame_tick), .sample_valid(sample_valid),
        .sample_in(sample_in), .sample_fmt(sample_fmt), .dither_on(dither_on),
        .dither_amplitude_select(dither_amplitude_select),
        .rounding_error_select(rounding_error_select), .marker_bit_enable(marker_bit_enable),
        .sync_receiver_on(sync_receiver_on), .cal_enable(cal_enable),
        .link_subsystem_enable(link_subsystem_enable), .link_hold_reset(link_hold_reset),
        .serializer_power_down(serializer_power_down), .link_clock_enable(link_clock_enable),
        .link_mode_select(link_mode_select),
        .frames_per_multiframe_minus_one(frames_per_multiframe_minus_one),
        .lmfc_boundary(lmfc_boundary), .ila_control_bits(ila_control_bits),
        .sample_out_valid(sample_out_valid), .sample_out(sample_out)
    );

    // ----------------------------------------
    // Bus tasks and model
    // ----------------------------------------
    task automatic wr(input int wa, input int wd);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= wa[11:0];
        reg_wdata <= wd[7:0];
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        if (m.exists(wa) && !(wa == 'h201 && wd[7:0] > m['h20F]))
            m[wa] = wd & 'hFF;
    endtask

    // Read strobe in the current cycle, so it may follow a write with no gap
    task automatic rd_go(input int ra);
        int ex;
        ex = m.exists(ra) ? m[ra] : 0;
        reg_rd <= 1'b1;
        reg_addr <= ra[11:0];
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        `CHK("reg_rdata", ex, reg_rdata)
    endtask

    task automatic rd_chk(input int ra);
        @(posedge ref_clk);
        rd_go(ra);
    endtask

    task automatic chk_out();
        int en;
        int kx;
        repeat (3) @(posedge ref_clk);
        #1;
        en = m['h200] & 1;
        kx = (m['h201] >= 'h10) ? 'hFF : m['h202];
        `CHK("dither_on", m['h09D] & 1, dither_on)
        `CHK("dither_amplitude_select", (m['h09D] >> 1) & 1, dither_amplitude_select)
        `CHK("rounding_error_select", (m['h09D] >> 2) & 1, rounding_error_select)
        `CHK("marker_bit_enable", m['h160] & 1, marker_bit_enable)
        `CHK("sync_receiver_on", (m['h20E] >> 1) & 1, sync_receiver_on)
        `CHK("cal_enable", m['h20E] & 1, cal_enable)
        `CHK("link_subsystem_enable", en, link_subsystem_enable)
        `CHK("link_hold_reset", 1 - en, link_hold_reset)
        `CHK("serializer_power_down", 1 - en, serializer_power_down)
        `CHK("link_clock_enable", en, link_clock_enable)
        `CHK("link_mode_select", m['h201], link_mode_select)
        `CHK("frames_per_multiframe_minus_one", kx, frames_per_multiframe_minus_one)
    endtask

    // ----------------------------------------
    // Sample path tasks
    // ----------------------------------------
    task automatic smp(input logic [11:0] sd, input int mk, input logic chk);
        logic mb;
        logic [11:0] ex;
        mb = (mk < 0) ? sd[0] : mk[0];
        ex = (sample_fmt == dlcr_pkg::DLCR_FMT_8BIT) ? {sd[11:5], mb, 4'h0} : {sd[11:1], mb};
        @(posedge ref_clk);
        sample_valid <= 1'b1;
        sample_in <= sd;
        @(posedge ref_clk);
        sample_valid <= 1'b0;
        #1;
        if (chk)
        begin
            `CHK("sample_out_valid", 1, sample_out_valid)
            `CHK("sample_out", ex, sample_out)
        end
    endtask

    task automatic burst(input logic sy, input dlcr_pkg::dlcr_fmt_t f, input int mk);
        @(posedge ref_clk);
        sync_pin <= sy;
        sample_fmt <= f;
        for (int i = 0; i < 8; i++)
            smp(12'($random(seed)), mk, i >= 5);
        `CHK("ila_control_bits", 0, ila_control_bits)
    endtask

    task automatic count_pulses(input logic toggle_sysref);
        pulses = 0;
        for (int i = 0; i < 40; i++)
        begin
            @(posedge ref_clk);
            sysref_pin <= toggle_sysref & i[2];
            #1;
            if (lmfc_boundary === 1'b1)
                pulses++;
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // Watchdog
    // ----------------------------------------
    initial
    begin
        repeat (100000) @(posedge ref_clk);
        bad_count++;
        finish_test();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        m['h09D] = 'h01;
        m['h160] = 'h00;
        m['h200] = 'h01;
        m['h201] = 'h02;
        m['h202] = 'h1F;
        m['h20E] = 'h01;
        m['h20F] = 'hFF;
        repeat (20) @(posedge ref_clk);
        arst_n <= 1'b1;
        chk_out();
        foreach (m[ra])
            rd_chk(ra);
        rd_chk('h123);
        @(posedge ref_clk);
        #1;
        `CHK("reg_rdata idle", 0, reg_rdata)
        wr('h200, 'h00);
        wr('h20E, 'h00);
        wr('h123, 'hAA);
        chk_out();
        for (int i = 0; i < 40; i++)
        begin
            k = $unsigned($random(seed)) % 6;
            a = (k == 5) ? 'h300 + ($unsigned($random(seed)) % 256) : addrs[k];
            d = $random(seed) & 'hFF;
            wr(a, d);
            rd_go(a);
            chk_out();
        end
        wr('h20F, 'h05);
        wr('h201, 'h07);
        rd_chk('h201);
        wr('h201, 'h04);
        rd_chk('h201);
        wr('h20F, 'hFF);
        wr('h201, 'h10);
        chk_out();
        wr('h201, 'h02);
        wr('h202, 'h03);
        wr('h20E, 'h03);
        wr('h200, 'h01);
        chk_out();
        @(posedge ref_clk);
        frame_tick <= 1'b1;
        repeat (5) @(posedge ref_clk);
        count_pulses(1'b0);
        `CHK("lmfc pulses enabled", 10, pulses)
        wr('h200, 'h00);
        chk_out();
        count_pulses(1'b1);
        `CHK("lmfc pulses disabled", 0, pulses)
        @(posedge ref_clk);
        sysref_pin <= 1'b0;
        frame_tick <= 1'b0;
        wr('h160, 'h01);
        chk_out();
        burst(1'b1, dlcr_pkg::DLCR_FMT_12BIT, 1);
        burst(1'b0, dlcr_pkg::DLCR_FMT_12BIT, 0);
        burst(1'b1, dlcr_pkg::DLCR_FMT_8BIT, 1);
        wr('h160, 'h00);
        burst(1'b1, dlcr_pkg::DLCR_FMT_12BIT, -1);
        finish_test();
    end
endmodule // testbench

`default_nettype wire
